// [logic/sicl_pkg.sv]
package sicl_pkg;
  localparam int SICL_DIV = 256;
  localparam int SICL_HALF = SICL_DIV / 2;
  localparam int SICL_LINE_BITS = 193;
  localparam int SICL_COUNT_BITS = 12;
  localparam int SICL_CFG_BITS = 304;
  localparam int SICL_PAD_BITS = 63;
  localparam int SICL_MBZ_LO = 0;
  localparam int SICL_MBZ_HI = 86;
  localparam int SICL_PAR_LO = 43;
  localparam int SICL_PAR_HI = 129;
  localparam int SICL_LP_FIRST = 172;
  localparam int SICL_IDX_W = 10;
  localparam logic [7:0] SICL_DIV_RESET = 8'h00;
  localparam logic [31:0] SICL_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] SICL_ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] SICL_ADDR_LINES = 32'h0000_0008;
  localparam logic [31:0] SICL_ADDR_CFG0 = 32'h0000_0010;
  localparam logic [1:0] SICL_OKAY = 2'b00;
  localparam logic [1:0] SICL_SLVERR = 2'b10;

  typedef enum logic [2:0] {SICL_IDLE, SICL_LINES, SICL_COUNT, SICL_CFG, SICL_PAD, SICL_DONE} sicl_state_type;

  // One cache line write toward the arrays
  typedef struct packed {
    logic [SICL_IDX_W-1:0] index;
    logic [SICL_LINE_BITS-1:0] image;
    logic mbz_error;
  } sicl_line_type;
endpackage : sicl_pkg

// [logic/sicl_loader.sv]
`timescale 1ns/100ps
module sicl_loader
  import sicl_pkg::*;
(
  input wire logic aclk, // Core clock, 100 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic rom_data_in, // Serial data from ROM
  output logic serial_rom_clock_out, // Divided clock to ROM
  output logic line_valid, // Line write offered to cache
  input wire logic line_ready, // Cache accepts line
  output sicl_line_type line_out, // Line payload
  output logic load_busy, // Fill in progress
  output logic load_done, // Whole stream consumed
  input wire logic [31:0] s_axi_awaddr, // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  sicl_state_type state;
  logic [7:0] div_cnt;
  logic [8:0] bit_cnt;
  logic [SICL_LINE_BITS-1:0] shift_reg;
  logic [SICL_COUNT_BITS-1:0] count_shift;
  logic [SICL_COUNT_BITS-1:0] lines_total;
  logic [SICL_IDX_W-1:0] next_index;
  logic [SICL_IDX_W-1:0] lines_loaded;
  logic [SICL_CFG_BITS-1:0] cfg_data;
  // Status flag stays set; line_mbz restarts per line so one bad image
  // does not mark every later line as bad too
  logic mbz_seen;
  logic line_mbz;
  logic [SICL_IDX_W-1:0] lines_loaded_pushed;
  logic stall_hold;
  logic [1:0] buf_cnt;
  sicl_line_type buf_q [2];
  logic buf_rd;
  logic buf_wr_ptr;
  logic [7:0] ctrl_tag;

  // End-of-field test shared by every phase counter
  function automatic logic is_last(input logic [8:0] cnt, input int total);
    is_last = (cnt == 9'(total - 1));
  endfunction : is_last

  // Sample point at divider midpoint, clock low in first half
  wire sample_tick = (div_cnt == 8'(SICL_HALF - 1)) && !stall_hold;
  wire active = (state != SICL_IDLE) && (state != SICL_DONE);
  wire buf_full = (buf_cnt == 2'd2);
  wire line_complete = sample_tick && (state == SICL_LINES) && is_last(bit_cnt, SICL_LINE_BITS);
  // Bits enter at the top, so a line's first bit ends up at bit zero
  wire [SICL_LINE_BITS-1:0] next_shift = {rom_data_in, shift_reg[SICL_LINE_BITS-1:1]};
  wire buf_push = line_complete;
  wire buf_pop = line_valid && line_ready;
  wire [SICL_COUNT_BITS-1:0] next_count = {rom_data_in, count_shift[SICL_COUNT_BITS-1:1]};
  wire mbz_bit_hit = (bit_cnt == 9'(SICL_MBZ_LO)) || (bit_cnt == 9'(SICL_MBZ_HI));

  // Divider free-runs while loading; held at zero on a line's last bit while the buffer is full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= SICL_DIV_RESET;
      stall_hold <= 1'b0;
    end else begin
      stall_hold <= buf_full && (state == SICL_LINES) && is_last(bit_cnt, SICL_LINE_BITS);
      if (active && !stall_hold) begin
        div_cnt <= div_cnt + 8'd1;
      end else begin
        div_cnt <= SICL_DIV_RESET;
      end
    end
  end

  // 50% duty: low for first half-period, high for second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_rom_clock_out <= 1'b0;
    end else begin
      serial_rom_clock_out <= active && div_cnt[7];
    end
  end

  // Stream sequencer; lines come first, then count, config and padding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SICL_IDLE;
      bit_cnt <= '0;
      shift_reg <= '0;
      count_shift <= '0;
      lines_total <= '0;
      cfg_data <= '0;
      mbz_seen <= 1'b0;
      line_mbz <= 1'b0;
    end else begin
      case (state)
        SICL_IDLE: begin
          state <= SICL_LINES;
        end
        SICL_LINES: begin
          // Leave between lines, ahead of the tick, so the next serial
          // bit lands in the count field instead of a dead line slot
          if (ctrl_tag[0] && bit_cnt == '0) begin
            state <= SICL_COUNT;
          end else if (sample_tick) begin
            shift_reg <= next_shift;
            if (rom_data_in && mbz_bit_hit) begin
              mbz_seen <= 1'b1;
              line_mbz <= 1'b1;
            end else if (line_complete) begin
              line_mbz <= 1'b0;
            end
            bit_cnt <= line_complete ? 9'd0 : bit_cnt + 9'd1;
          end
        end
        SICL_COUNT: begin
          if (sample_tick) begin
            count_shift <= next_count;
            bit_cnt <= bit_cnt + 9'd1;
            if (is_last(bit_cnt, SICL_COUNT_BITS)) begin
              lines_total <= next_count;
              bit_cnt <= '0;
              state <= SICL_CFG;
            end
          end
        end
        SICL_CFG: begin
          if (sample_tick) begin
            cfg_data <= {rom_data_in, cfg_data[SICL_CFG_BITS-1:1]};
            bit_cnt <= bit_cnt + 9'd1;
            if (is_last(bit_cnt, SICL_CFG_BITS)) begin
              bit_cnt <= '0;
              state <= SICL_PAD;
            end
          end
        end
        SICL_PAD: begin
          if (sample_tick) begin
            bit_cnt <= bit_cnt + 9'd1;
            if (is_last(bit_cnt, SICL_PAD_BITS)) begin
              state <= SICL_DONE;
            end
          end
        end
        SICL_DONE: begin
          state <= SICL_DONE;
        end
        default: begin
          state <= SICL_IDLE;
        end
      endcase
    end
  end

  // Stream has no end marker for lines, so the line phase length is
  // supplied as a strap-free line budget written over the bus
  logic [SICL_IDX_W-1:0] line_budget;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_tag <= 8'h00;
    end else begin
      ctrl_tag[0] <= (state == SICL_LINES) && (lines_loaded_pushed == line_budget);
      ctrl_tag[7:1] <= 7'h00;
    end
  end

  // Lines queued so far; a zero budget skips the fill entirely
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lines_loaded_pushed <= '0;
    end else if (buf_push) begin
      lines_loaded_pushed <= lines_loaded_pushed + 10'd1;
    end
  end

  // Two-entry buffer between shift register and cache write port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_cnt <= 2'd0;
      buf_rd <= 1'b0;
      buf_wr_ptr <= 1'b0;
      next_index <= '0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (buf_push && !buf_full) begin
        buf_q[buf_wr_ptr] <= '{index: next_index, image: next_shift, mbz_error: line_mbz};
        buf_wr_ptr <= ~buf_wr_ptr;
        next_index <= next_index + 10'd1;
      end
      if (buf_pop) begin
        buf_rd <= ~buf_rd;
      end
      buf_cnt <= buf_cnt + 2'(buf_push && !buf_full) - 2'(buf_pop);
    end
  end

  // Offer stands as soon as a line is buffered; valid never waits on ready
  assign line_valid = (buf_cnt != 2'd0);
  assign line_out = buf_q[buf_rd];

  // Loaded-line count shown to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lines_loaded <= '0;
    end else if (buf_pop) begin
      lines_loaded <= lines_loaded + 10'd1;
    end
  end

  // Busy covers buffered lines too, so done means the cache holds them all
  assign load_busy = active || (buf_cnt != 2'd0);
  assign load_done = (state == SICL_DONE) && (buf_cnt == 2'd0);

  // AXI4-Lite write: budget register, taken when address and data both held
  // Budget only lands before the fill starts; later writes are acknowledged but dropped
  logic aw_hold, w_hold;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  wire wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SICL_OKAY;
      line_budget <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == SICL_ADDR_LINES) ? SICL_OKAY : SICL_SLVERR;
        if (aw_addr_q == SICL_ADDR_LINES && state == SICL_IDLE) begin
          line_budget <= w_data_q[SICL_IDX_W-1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready = !w_hold;

  // AXI4-Lite read: status, count and first config word
  // Answered one cycle after the address, never stalled by the loader
  wire [31:0] rd_word =
    (s_axi_araddr == SICL_ADDR_STAT) ? {29'h0, mbz_seen, load_done, load_busy} :
    (s_axi_araddr == SICL_ADDR_LINES) ? {20'h0, lines_total} :
    (s_axi_araddr == SICL_ADDR_CTRL) ? {22'h0, lines_loaded} :
    (s_axi_araddr == SICL_ADDR_CFG0) ? cfg_data[31:0] : 32'h0;
  wire rd_ok = (s_axi_araddr == SICL_ADDR_STAT) || (s_axi_araddr == SICL_ADDR_LINES) ||
               (s_axi_araddr == SICL_ADDR_CTRL) || (s_axi_araddr == SICL_ADDR_CFG0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SICL_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? SICL_OKAY : SICL_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

endmodule : sicl_loader

// [verification/sicl_rom_model.sv]
`timescale 1ns/100ps
module sicl_rom_model
  import sicl_pkg::*;
#(
  parameter logic [11:0] LINE_COUNT = 12'h000,
  parameter logic [31:0] CFG_LOW = 32'ha5c3_0f96
)
(
  input wire logic serial_rom_clock_out, // Clock from loader
  output logic rom_data_in // Data to loader
);
  localparam int TOTAL = SICL_COUNT_BITS + SICL_CFG_BITS + SICL_PAD_BITS;
  int idx = 0;
  logic risen = 1'b0;
  // Count field, config section, zero pad, each LSB first
  function automatic logic bit_at(input int k);
    // Count field as the image gives it; a nonzero count carries 3 in its top two bits
    if (k < SICL_COUNT_BITS) return LINE_COUNT[k];
    if (k < SICL_COUNT_BITS + 32) return CFG_LOW[k - SICL_COUNT_BITS];
    if (k < SICL_COUNT_BITS + SICL_CFG_BITS) return k[0];
    return 1'b0;
  endfunction : bit_at
  // Advance on real falls only; the drop out of X at start is not a clock
  always @(posedge serial_rom_clock_out) risen <= 1'b1;
  always @(negedge serial_rom_clock_out) if (risen) idx <= idx + 1;
  // Past the end the line shows the inverse of the last pad bit
  assign rom_data_in = (idx < TOTAL) ? bit_at(idx) : 1'b1;
endmodule : sicl_rom_model

// [verification/sicl_loader_properties.sv]
`timescale 1ns/100ps
module sicl_loader_properties
  import sicl_pkg::*;
(
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Sync reset
  input wire logic serial_rom_clock_out, // Serial clock
  input wire logic line_valid, // Line offer
  input wire logic line_ready, // Line accept
  input wire sicl_line_type line_out, // Line payload
  input wire logic load_busy, // Busy
  input wire logic load_done, // Done
  input wire logic s_axi_bvalid, // Write answer
  input wire logic s_axi_bready, // Write accept
  input wire logic s_axi_rvalid, // Read answer
  input wire logic s_axi_rready, // Read accept
  input wire logic [31:0] s_axi_rdata // Read data
);
  logic sq;
  logic seen;
  logic [7:0] run;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Half-period length; first run skipped, start phase is loose
  always_ff @(posedge aclk) begin
    sq <= serial_rom_clock_out;
    run <= (serial_rom_clock_out != sq) ? 8'h00 : run + 8'h01;
    seen <= aresetn & (seen | (serial_rom_clock_out != sq));
  end
  a_half_period: assert property ((serial_rom_clock_out != sq) && seen && load_busy |-> run == 8'd127)
    else $error("serial clock half period wrong");
  a_done_clk_low: assert property (load_done |-> !serial_rom_clock_out)
    else $error("serial clock runs after done");
  a_auto_start: assert property ($rose(aresetn) |-> ##1 load_busy)
    else $error("fill did not start");
  a_done_sticky: assert property (load_done |=> load_done && !load_busy)
    else $error("done dropped");
  a_line_hold: assert property (line_valid && !line_ready |=> line_valid && $stable(line_out))
    else $error("line offer changed");
  a_mbz_flag: assert property (line_valid |-> line_out.mbz_error == (line_out.image[0] | line_out.image[86]))
    else $error("mbz flag wrong");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  c_clk: cover property ($rose(serial_rom_clock_out));
  c_done: cover property ($rose(load_done));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sicl_loader_properties

bind sicl_loader sicl_loader_properties i_props (.aclk(aclk), .aresetn(aresetn),
  .serial_rom_clock_out(serial_rom_clock_out), .line_valid(line_valid), .line_ready(line_ready),
  .line_out(line_out), .load_busy(load_busy), .load_done(load_done), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));

// [verification/sicl_loader_tb.sv]
`timescale 1ns/100ps
module sicl_loader_tb
  import sicl_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic line_ready = 1'b1;
  logic rom_data_in, serial_rom_clock_out, line_valid, load_busy, load_done;
  sicl_line_type line_out;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic line_seen = 1'b0;
  int n_fail = 0, checked = 0, cycles = 0;
  // No lines in bits 9:0; the upper bits show that the field is read in place
  localparam logic [11:0] ROM_COUNT = 12'hc00;

  always #5 aclk = ~aclk;

  sicl_loader i_dut (.aclk, .aresetn, .rom_data_in, .serial_rom_clock_out, .line_valid, .line_ready,
    .line_out, .load_busy, .load_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sicl_rom_model #(.LINE_COUNT(ROM_COUNT)) i_rom (.serial_rom_clock_out, .rom_data_in);

  // Watchdog sized above the whole stream; also notes any line offer
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (line_valid === 1'b1) line_seen <= 1'b1;
    if (cycles == 99000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task complete_run;
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
    cmp(s_axi_rdata, exp);
  endtask : axi_rd

  // Busy by itself after reset; unmapped places refused
  task automatic t_start;
    axi_rd(SICL_ADDR_STAT, 32'h1, SICL_OKAY);
    axi_wr(SICL_ADDR_LINES, 32'h5, SICL_OKAY);
    axi_rd(32'h0000_000c, 32'h0, SICL_SLVERR);
    axi_wr(32'h0000_0020, 32'h1, SICL_SLVERR);
  endtask : t_start

  // One serial bit per divider period, high and low halves equal
  task automatic t_serial;
    int hi, lo;
    hi = 0;
    lo = 0;
    while (serial_rom_clock_out !== 1'b1) @(posedge aclk);
    while (serial_rom_clock_out === 1'b1) begin
      @(posedge aclk);
      hi++;
    end
    while (serial_rom_clock_out === 1'b0) begin
      @(posedge aclk);
      lo++;
    end
    cmp(32'(hi), 32'(SICL_HALF));
    cmp(32'(hi + lo), 32'(SICL_DIV));
  endtask : t_serial

  // Zero line count: no line offered, config bits arrive LSB first
  task automatic t_stream;
    while (load_done !== 1'b1) @(posedge aclk);
    cmp({31'h0, line_seen}, 32'h0);
    axi_rd(SICL_ADDR_CTRL, 32'h0, SICL_OKAY);
    axi_rd(SICL_ADDR_LINES, {20'h0, ROM_COUNT}, SICL_OKAY);
    axi_rd(SICL_ADDR_CFG0, 32'ha5c3_0f96, SICL_OKAY);
    axi_rd(SICL_ADDR_STAT, 32'h2, SICL_OKAY);
  endtask : t_stream

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_start;
    t_serial;
    t_stream;
    complete_run;
  end
endmodule : sicl_loader_tb
